// file: sds_pkg.sv
// Package for the speed drive state machine: register map, field positions,
// reset values, states and the status word layout.
// Assumes a single pclk domain and an APB master with 32-bit data.
//
// Functional notes
// - Inhibited state: bit6 high, bits 2..0 low
// - Ready state: bit6 low, bits 2..0 001
// - Switched on 011, operation 111, bit6 low
// - Ramp or quick stop: bits 011, bit6 low
// - Quick stop is its own state 6
// - Status bit4 copies control bit1
// - Status bit5 copies control bit2
// - Status bit9 copies control bit10
// - Status bit3 shows external fault input
// - Status bit7 shows external warning input
// - Control bit7 acknowledges and clears faults
// - Status bit8 set inside speed window
// - Status bit10 set at or above threshold
// - Control bit6 feeds setpoint to ramp input
// - Control bit5 ramps linearly, else holds
// - Control bit4 gates ramp value to output
// - Ramp setpoint passes only in state 4
// - On error ramp down at emergency slope
// - Sign-of-life failure raises error, stops drive
// - Tolerated failure count; zero means none
// - Ignore control bits 11..15, status bits zero
// - Output setpoint as percent of reference
package sds_pkg;

    localparam int unsigned ADDR_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SETPOINT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RAMP_SLP  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EMERG_SLP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_WINDOW    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_REF_SPEED = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_HB_TOL    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_STAT_ONE  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STAT_TWO  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_PROC_SP   = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_PERCENT   = 8'h30;

    // Control word one bit positions.
    localparam int unsigned CB_ON_OFF      = 0;
    localparam int unsigned CB_COAST_REL   = 1;
    localparam int unsigned CB_QSTOP_REL   = 2;
    localparam int unsigned CB_ENABLE_OP   = 3;
    localparam int unsigned CB_RAMP_ENABLE = 4;
    localparam int unsigned CB_RAMP_RUN    = 5;
    localparam int unsigned CB_SP_ENABLE   = 6;
    localparam int unsigned CB_FAULT_ACK   = 7;
    localparam int unsigned CB_CTRL_REQ    = 10;

    // Sign-of-life field in both second words.
    localparam int unsigned LIFE_LSB = 12;
    localparam int unsigned LIFE_W   = 4;

    // Reset values and the percent scale factor.
    localparam logic [15:0] RST_RAMP_SLOPE  = 16'h0010;
    localparam logic [15:0] RST_EMERG_SLOPE = 16'h0040;
    localparam logic [15:0] RST_WINDOW      = 16'h0020;
    localparam logic [15:0] RST_THRESHOLD   = 16'h4000;
    localparam logic [15:0] RST_REF_SPEED   = 16'h4000;
    localparam logic [7:0]  RST_HB_TOL      = 8'h00;
    localparam logic signed [31:0] PCT_SCALE = 32'sh00000064;

    typedef enum logic [5:0] {
        ST_S1 = 6'b000001,
        ST_S2 = 6'b000010,
        ST_S3 = 6'b000100,
        ST_S4 = 6'b001000,
        ST_S5 = 6'b010000,
        ST_S6 = 6'b100000
    } sds_state_t;

    typedef struct packed {
        logic [4:0] drive_spec;
        logic       speed_reached;
        logic       ctrl_requested;
        logic       speed_in_tol;
        logic       warning;
        logic       on_inhibited;
        logic       qstop_off;
        logic       coast_off;
        logic       fault;
        logic       op_enabled;
        logic       ready_operate;
        logic       ready_on;
    } sds_status_t;

endpackage

// file: sds_drive.sv
// Speed drive state machine with ramp generator, speed monitors and
// sign-of-life supervision, reached over APB.
// Assumes an APB master on pclk; a write to control word two ends one
// telegram cycle; actual speed, fault and warning are synchronous inputs.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module sds_drive
    import sds_pkg::*;
(
    input  wire logic                 pclk,                 // Clock, 25 MHz
    input  wire logic                 presetn,              // Async reset, low
    input  wire logic                 psel,                 // APB select
    input  wire logic                 penable,              // APB enable
    input  wire logic                 pwrite,               // APB direction
    input  wire logic [ADDR_W-1:0]    paddr,                // APB byte address
    input  wire logic [31:0]          pwdata,               // APB write data
    output logic      [31:0]          prdata,               // APB read data
    output logic                      pready,               // APB ready
    output logic                      pslverr,              // APB error
    input  wire logic signed [15:0]   actual_speed,         // Actual speed
    input  wire logic                 drive_fault_in,       // External fault
    input  wire logic                 drive_warning_in,     // External warning
    output sds_status_t               status_word_one,      // Status word one
    output logic      [15:0]          status_word_two,      // Status word two
    output logic signed [15:0]        process_setpoint_speed, // Setpoint out
    output logic signed [15:0]        setpoint_percent,     // Setpoint in %
    output logic                      life_error            // Sign-of-life error
);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic        [15:0] control_word_one_q;
    logic        [15:0] control_word_two_q;
    logic signed [15:0] speed_setpoint_in_q;
    logic        [15:0] ramp_slope_param_q;
    logic        [15:0] emergency_slope_param_q;
    logic        [15:0] tolerance_window_width_q;
    logic signed [15:0] speed_compare_level_q;
    logic        [15:0] nominal_speed_ref_q;
    logic        [7:0]  tolerated_heartbeat_failures_q;
    logic        [31:0] prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic        [31:0] rdata_d;
    logic               hit_d;
    logic               apb_wr;
    logic               cycle_end;

    assign apb_wr    = psel && penable && pwrite && pready_q;
    assign cycle_end = apb_wr && (paddr == OFS_CTRL_TWO);

    always_comb
    begin
        rdata_d = 32'h00000000;
        hit_d   = 1'b1;
        case (paddr)
            OFS_CTRL_ONE:  rdata_d = {16'h0000, control_word_one_q};
            OFS_CTRL_TWO:  rdata_d = {16'h0000, control_word_two_q};
            OFS_SETPOINT:  rdata_d = {16'h0000, speed_setpoint_in_q};
            OFS_RAMP_SLP:  rdata_d = {16'h0000, ramp_slope_param_q};
            OFS_EMERG_SLP: rdata_d = {16'h0000, emergency_slope_param_q};
            OFS_WINDOW:    rdata_d = {16'h0000, tolerance_window_width_q};
            OFS_THRESHOLD: rdata_d = {16'h0000, speed_compare_level_q};
            OFS_REF_SPEED: rdata_d = {16'h0000, nominal_speed_ref_q};
            OFS_HB_TOL:    rdata_d = {24'h000000, tolerated_heartbeat_failures_q};
            OFS_STAT_ONE:  rdata_d = {16'h0000, status_word_one};
            OFS_STAT_TWO:  rdata_d = {16'h0000, status_word_two};
            OFS_PROC_SP:   rdata_d = {16'h0000, process_setpoint_speed};
            OFS_PERCENT:   rdata_d = {16'h0000, setpoint_percent};
            default:       hit_d   = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !hit_d;
            if (psel && penable && !pready_q && !pwrite)
            begin
                prdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_word_one_q             <= 16'h0000;
            control_word_two_q             <= 16'h0000;
            speed_setpoint_in_q            <= 16'sh0000;
            ramp_slope_param_q             <= RST_RAMP_SLOPE;
            emergency_slope_param_q        <= RST_EMERG_SLOPE;
            tolerance_window_width_q       <= RST_WINDOW;
            speed_compare_level_q          <= RST_THRESHOLD;
            nominal_speed_ref_q            <= RST_REF_SPEED;
            tolerated_heartbeat_failures_q <= RST_HB_TOL;
        end
        else if (apb_wr)
        begin
            case (paddr)
                OFS_CTRL_ONE:  control_word_one_q             <= pwdata[15:0];
                OFS_CTRL_TWO:  control_word_two_q             <= pwdata[15:0];
                OFS_SETPOINT:  speed_setpoint_in_q            <= pwdata[15:0];
                OFS_RAMP_SLP:  ramp_slope_param_q             <= pwdata[15:0];
                OFS_EMERG_SLP: emergency_slope_param_q        <= pwdata[15:0];
                OFS_WINDOW:    tolerance_window_width_q       <= pwdata[15:0];
                OFS_THRESHOLD: speed_compare_level_q          <= pwdata[15:0];
                OFS_REF_SPEED: nominal_speed_ref_q            <= pwdata[15:0];
                OFS_HB_TOL:    tolerated_heartbeat_failures_q <= pwdata[7:0];
                default:       ;
            endcase
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sign-of-life supervision and fault acknowledge.

    logic [LIFE_W-1:0] life_seen_q;
    logic [LIFE_W-1:0] life_echo_q;
    logic [LIFE_W-1:0] life_new;
    logic [7:0]        miss_cnt_q;
    logic              life_err_q;
    logic              ack_prev_q;
    logic              ack_rise;
    logic              life_miss;
    logic              life_err_set;

    assign life_new     = pwdata[LIFE_LSB +: LIFE_W];
    assign life_miss    = cycle_end && (life_new == life_seen_q);
    assign life_err_set = life_miss && (miss_cnt_q >= tolerated_heartbeat_failures_q);
    assign ack_rise     = control_word_one_q[CB_FAULT_ACK] && !ack_prev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            life_seen_q <= '0;
            life_echo_q <= '0;
            miss_cnt_q  <= 8'h00;
            life_err_q  <= 1'b0;
            ack_prev_q  <= 1'b0;
        end
        else
        begin
            ack_prev_q <= control_word_one_q[CB_FAULT_ACK];
            if (cycle_end)
            begin
                life_seen_q <= life_new;
                life_echo_q <= life_echo_q + LIFE_W'(1);
                if (!life_miss)
                begin
                    miss_cnt_q <= 8'h00;
                end
                else if (miss_cnt_q != 8'hFF)
                begin
                    miss_cnt_q <= miss_cnt_q + 8'h01;
                end
            end
            // A new failure wins over an acknowledge in the same cycle.
            if (life_err_set)
            begin
                life_err_q <= 1'b1;
            end
            else if (ack_rise)
            begin
                life_err_q <= 1'b0;
            end
        end
    end

    assign life_error = life_err_q;

    ////////////////////////////////////////////////////////////////////////////
    // State machine.

    sds_state_t state_q;
    sds_state_t state_d;
    logic       any_err;
    logic signed [15:0] ramp_q;
    logic       ramp_zero;

    assign any_err   = life_err_q || drive_fault_in;
    assign ramp_zero = (ramp_q == 16'sh0000);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_S1:
                if (!any_err && !control_word_one_q[CB_ON_OFF]
                    && control_word_one_q[CB_QSTOP_REL])
                    state_d = ST_S2;
            ST_S2:
                if (any_err || !control_word_one_q[CB_QSTOP_REL])
                    state_d = ST_S1;
                else if (control_word_one_q[CB_ON_OFF])
                    state_d = ST_S3;
            ST_S3:
                if (any_err || !control_word_one_q[CB_QSTOP_REL])
                    state_d = ST_S1;
                else if (!control_word_one_q[CB_ON_OFF])
                    state_d = ST_S2;
                else if (control_word_one_q[CB_ENABLE_OP])
                    state_d = ST_S4;
            ST_S4:
                if (any_err || !control_word_one_q[CB_QSTOP_REL])
                    state_d = ST_S6;
                else if (!control_word_one_q[CB_ON_OFF])
                    state_d = ST_S5;
                else if (!control_word_one_q[CB_ENABLE_OP])
                    state_d = ST_S3;
            ST_S5:
                if (any_err || !control_word_one_q[CB_QSTOP_REL])
                    state_d = ST_S6;
                else if (ramp_zero)
                    state_d = ST_S2;
            ST_S6:
                if (ramp_zero)
                    state_d = ST_S1;
            default:
                state_d = ST_S1;
        endcase
        if (!control_word_one_q[CB_COAST_REL])
        begin
            state_d = ST_S1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_S1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ramp function generator.

    logic signed [15:0] ramp_target;
    logic        [15:0] ramp_slope;
    logic               ramp_step;
    logic signed [16:0] ramp_diff;
    logic signed [16:0] slope_ext;
    logic signed [15:0] ramp_d;

    always_comb
    begin
        ramp_target = control_word_one_q[CB_SP_ENABLE] ? speed_setpoint_in_q : 16'sh0000;
        ramp_slope  = ramp_slope_param_q;
        ramp_step   = control_word_one_q[CB_RAMP_RUN];
        if (state_q != ST_S4)
        begin
            ramp_target = 16'sh0000;
            ramp_step   = 1'b1;
        end
        if (state_q == ST_S6 || any_err)
        begin
            ramp_slope = emergency_slope_param_q;
        end
        slope_ext = $signed({1'b0, ramp_slope});
        ramp_diff = 17'(ramp_target) - 17'(ramp_q);
        if (ramp_diff > slope_ext)
            ramp_d = 16'(17'(ramp_q) + slope_ext);
        else if (ramp_diff < -slope_ext)
            ramp_d = 16'(17'(ramp_q) - slope_ext);
        else
            ramp_d = ramp_target;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_q <= 16'sh0000;
        end
        else if (ramp_step)
        begin
            ramp_q <= ramp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint outputs.

    logic signed [15:0] proc_sp_d;
    logic signed [15:0] proc_sp_q;
    logic signed [15:0] pct_q;
    logic signed [31:0] pct_num;
    logic signed [31:0] pct_full;

    assign proc_sp_d = (state_q == ST_S4 && control_word_one_q[CB_RAMP_ENABLE])
                       ? ramp_q : 16'sh0000;
    assign pct_num   = 32'(proc_sp_q) * PCT_SCALE;
    assign pct_full  = (nominal_speed_ref_q == 16'h0000) ? 32'sh00000000
                       : pct_num / $signed({16'h0000, nominal_speed_ref_q});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            proc_sp_q <= 16'sh0000;
            pct_q     <= 16'sh0000;
        end
        else
        begin
            proc_sp_q <= proc_sp_d;
            pct_q     <= 16'(pct_full);
        end
    end

    assign process_setpoint_speed = proc_sp_q;
    assign setpoint_percent       = pct_q;

    ////////////////////////////////////////////////////////////////////////////
    // Status words.

    sds_status_t        sw1_d;
    sds_status_t        sw1_q;
    logic        [15:0] sw2_q;
    logic signed [17:0] spd_err;
    logic        [17:0] spd_abs;

    assign spd_err = 18'(actual_speed) - 18'(speed_setpoint_in_q);
    assign spd_abs = spd_err[17] ? 18'(-spd_err) : 18'(spd_err);

    always_comb
    begin
        sw1_d = '0;
        sw1_d.ready_on      = (state_q != ST_S1);
        sw1_d.ready_operate = (state_q == ST_S3) || (state_q == ST_S4)
                              || (state_q == ST_S5) || (state_q == ST_S6);
        sw1_d.op_enabled    = (state_q == ST_S4);
        sw1_d.on_inhibited  = (state_q == ST_S1);
        sw1_d.fault         = drive_fault_in || life_err_q;
        sw1_d.warning       = drive_warning_in;
        sw1_d.coast_off     = control_word_one_q[CB_COAST_REL];
        sw1_d.qstop_off     = control_word_one_q[CB_QSTOP_REL];
        sw1_d.ctrl_requested = control_word_one_q[CB_CTRL_REQ];
        sw1_d.speed_in_tol  = ({spd_abs, 1'b0} <= {3'b000, tolerance_window_width_q});
        sw1_d.speed_reached = (actual_speed >= speed_compare_level_q);
        sw1_d.drive_spec    = 5'h00;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw1_q <= '0;
            sw2_q <= 16'h0000;
        end
        else
        begin
            sw1_q <= sw1_d;
            sw2_q <= {life_echo_q, 12'h000};
        end
    end

    assign status_word_one = sw1_q;
    assign status_word_two = sw2_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_access_s;
        psel && penable && !pready_q;
    endsequence

    inhibit_status_a: assert property ((state_q == ST_S1) |=>
        (sw1_q.on_inhibited && sw1_q[2:0] == 3'b000))
        else $error("inhibited status word wrong");

    ready_status_a: assert property ((state_q == ST_S2) |=>
        (!sw1_q.on_inhibited && sw1_q[2:0] == 3'b001))
        else $error("ready status word wrong");

    run_status_a: assert property ((state_q == ST_S4) |=>
        (!sw1_q.on_inhibited && sw1_q[2:0] == 3'b111))
        else $error("operation status word wrong");

    stop_status_a: assert property ((state_q == ST_S5 || state_q == ST_S6
        || state_q == ST_S3) |=> (!sw1_q.on_inhibited && sw1_q[2:0] == 3'b011))
        else $error("stop status word wrong");

    copy_bits_a: assert property (1'b1 |=>
        (sw1_q.coast_off == $past(control_word_one_q[CB_COAST_REL])
         && sw1_q.qstop_off == $past(control_word_one_q[CB_QSTOP_REL])
         && sw1_q.ctrl_requested == $past(control_word_one_q[CB_CTRL_REQ])))
        else $error("copied status bits wrong");

    spec_zero_a: assert property (sw1_q.drive_spec == 5'h00)
        else $error("drive specific status bits not zero");

    sp_gate_a: assert property ((state_q != ST_S4) |=> (proc_sp_q == 16'sh0000))
        else $error("setpoint passed outside operation");

    coast_force_a: assert property (!control_word_one_q[CB_COAST_REL] |=>
        (state_q == ST_S1))
        else $error("coast stop did not force inhibited state");

    life_zero_a: assert property ((tolerated_heartbeat_failures_q == 8'h00
        && life_miss) |=> life_err_q)
        else $error("single miss did not raise error");

    apb_wait_a: assert property (apb_access_s |=> (pready_q ##1 !pready_q))
        else $error("apb ready timing wrong");

endmodule

`default_nettype wire

// file: sds_plant.sv
// Plant model for the speed drive: actual speed follows the setpoint.
// Assumes one pclk domain; the bench adds a speed offset.
`timescale 1ns/1ns
`default_nettype none

module sds_plant
(
    input  wire logic signed [15:0] setpoint, // Setpoint from drive
    input  wire logic signed [15:0] offset,   // Speed error to add
    input  wire logic               pclk,     // Clock
    input  wire logic               presetn,  // Async reset, low
    output logic signed [15:0]      actual    // Actual speed
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            actual <= 16'sh0000;
        else
            actual <= setpoint + offset;
    end
endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the speed drive: APB tasks and directed tests.
// Assumes sds_drive and the plant model sds_plant.
`timescale 1ns/1ns
`default_nettype none

module testbench
    import sds_pkg::*;
;
    logic               pclk = 1'b0;
    logic               presetn, psel, penable, pwrite, pready, pslverr;
    logic               fault_in, warn_in, life_error, err;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdata;
    logic signed [15:0] actual, psp, pct, offset;
    logic [15:0]        sw2;
    sds_status_t        sw1;
    int                 failures, check_count, n;

    always #20 pclk = ~pclk;

    sds_drive dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .actual_speed(actual),
        .drive_fault_in(fault_in), .drive_warning_in(warn_in), .status_word_one(sw1),
        .status_word_two(sw2), .process_setpoint_speed(psp), .setpoint_percent(pct),
        .life_error(life_error));

    sds_plant plant_u (.setpoint(psp), .offset(offset), .pclk(pclk), .presetn(presetn),
        .actual(actual));

    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
            failures++;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, e);
    endtask

    // Counts cycles spent stopping (bits 2..0 = 011) after operation ends.
    task stop_len();
        n = 0;
        while (sw1.op_enabled !== 1'b0 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while ({sw1.ready_operate, sw1.ready_on, sw1.on_inhibited} === 3'b110 && n < 80)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task end_of_test();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(40 * 20000);
        failures++;
        end_of_test();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, fault_in, warn_in} <= 6'h00;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        offset <= 16'sh0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_STAT_ONE, 32'h0040, 32'hFEFF);
        rd(OFS_RAMP_SLP, 32'(RST_RAMP_SLOPE));
        rd(OFS_EMERG_SLP, 32'(RST_EMERG_SLOPE));
        rd(OFS_WINDOW, 32'(RST_WINDOW));
        rd(OFS_REF_SPEED, 32'(RST_REF_SPEED));
        rd(OFS_HB_TOL, 32'(RST_HB_TOL));
        rd(8'h40, 32'h0);
        chk(32'(err), 32'h1);
        wr(OFS_CTRL_TWO, 32'h1000);
        wr(OFS_CTRL_TWO, 32'h2000);
        chk(32'(life_error), 32'h0);
        wr(OFS_CTRL_TWO, 32'h3000);
        repeat (2) @(posedge pclk);
        chk(32'(sw2), 32'h3000);
        wr(OFS_CTRL_TWO, 32'h3000);
        chk(32'(life_error), 32'h1);
        wr(OFS_CTRL_ONE, 32'h0080);
        wr(OFS_CTRL_ONE, 32'h0000);
        chk(32'(life_error), 32'h0);
        wr(OFS_HB_TOL, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL_TWO, 32'h4000);
            chk(32'(life_error), 32'(i == 3));
        end
        wr(OFS_CTRL_ONE, 32'h0080);
        wr(OFS_CTRL_ONE, 32'h0000);
        wr(OFS_CTRL_ONE, 32'hFC06);
        rd(OFS_STAT_ONE, 32'h0231, 32'hFEFF);
        wr(OFS_CTRL_ONE, 32'hFC07);
        rd(OFS_STAT_ONE, 32'h0233, 32'hFEFF);
        wr(OFS_SETPOINT, 32'h0100);
        wr(OFS_THRESHOLD, 32'h0080);
        wr(OFS_CTRL_ONE, 32'hFC7F);
        repeat (40) @(posedge pclk);
        rd(OFS_STAT_ONE, 32'h0737);
        rd(OFS_PROC_SP, 32'h0100);
        rd(OFS_PERCENT, 32'h0001);
        warn_in <= 1'b1;
        offset <= 16'sh0011;
        repeat (3) @(posedge pclk);
        rd(OFS_STAT_ONE, 32'h06B7);
        offset <= 16'sh0010;
        repeat (3) @(posedge pclk);
        rd(OFS_STAT_ONE, 32'h07B7);
        warn_in <= 1'b0;
        offset <= 16'sh0000;
        wr(OFS_CTRL_ONE, 32'hFC5F);
        wr(OFS_SETPOINT, 32'h0200);
        repeat (40) @(posedge pclk);
        rd(OFS_PROC_SP, 32'h0100);
        wr(OFS_CTRL_ONE, 32'hFC4F);
        rd(OFS_PROC_SP, 32'h0000);
        wr(OFS_CTRL_ONE, 32'hFC7F);
        repeat (40) @(posedge pclk);
        rd(OFS_PROC_SP, 32'h0200);
        wr(OFS_CTRL_ONE, 32'hFC7E);
        stop_len();
        chk(32'(n >= 29 && n <= 36), 32'h1);
        rd(OFS_STAT_ONE, 32'h0231, 32'hFEFF);
        wr(OFS_CTRL_ONE, 32'hFC7F);
        repeat (40) @(posedge pclk);
        wr(OFS_CTRL_ONE, 32'hFC7B);
        stop_len();
        chk(32'(n >= 6 && n <= 11), 32'h1);
        rd(OFS_STAT_ONE, 32'h0250, 32'hFEFF);
        wr(OFS_CTRL_ONE, 32'hFC06);
        wr(OFS_CTRL_ONE, 32'hFC7F);
        repeat (40) @(posedge pclk);
        fault_in <= 1'b1;
        stop_len();
        chk(32'(n >= 6 && n <= 11), 32'h1);
        rd(OFS_STAT_ONE, 32'h0278, 32'hFEFF);
        fault_in <= 1'b0;
        wr(OFS_CTRL_ONE, 32'hFC06);
        wr(OFS_CTRL_ONE, 32'hFC07);
        wr(OFS_CTRL_ONE, 32'hFC05);
        rd(OFS_STAT_ONE, 32'h0260, 32'hFEFF);
        end_of_test();
    end
endmodule

`default_nettype wire
